//--- design/rach_pkg.sv
// constants, codes and helpers of the relay and alarm command handler
// assumes ascii frames arrive one byte at a time from a same-clock receiver
package rach_pkg;
  localparam logic [7:0] CHR_AT = 8'h40;
  localparam logic [7:0] CHR_TILDE = 8'h7E;
  localparam logic [7:0] CHR_OK = 8'h21;
  localparam logic [7:0] CHR_BAD = 8'h3F;
  localparam logic [7:0] CHR_CR = 8'h0D;
  localparam logic [7:0] CHR_ZERO = 8'h30;
  localparam logic [7:0] CHR_A = 8'h41;
  localparam logic [7:0] CHR_C = 8'h43;
  localparam logic [7:0] CHR_D = 8'h44;
  localparam logic [7:0] CHR_E = 8'h45;
  localparam logic [7:0] CHR_H = 8'h48;
  localparam logic [7:0] CHR_I = 8'h49;
  localparam logic [7:0] CHR_L = 8'h4C;
  localparam logic [7:0] CHR_M = 8'h4D;
  localparam logic [7:0] CHR_O = 8'h4F;
  localparam logic [7:0] RELAY_OFF = 8'h00;
  localparam logic [7:0] RELAY_ON = 8'h01;
  localparam int POL_BIT = 2;
  localparam logic [7:0] POL_RSVD_MASK = 8'hFB;
  localparam logic [7:0] POL_RESET = 8'h00;
  localparam logic [3:0] FRAME_MAX = 4'hA;
  localparam int REPLY_MAX = 9;
  localparam logic [3:0] LEN_SHORT = 4'h4;
  localparam logic [3:0] LEN_STATUS = 4'h5;
  localparam logic [3:0] LEN_MID = 4'h6;
  localparam logic [3:0] LEN_DO = 4'h7;

  typedef enum logic [1:0] {ALM_OFF, ALM_MOM, ALM_LATCH} rach_alarm_e;
  typedef enum logic [1:0] {ST_RECV, ST_DECODE, ST_SEND} rach_state_e;

  // returns {valid, nibble}
  function automatic logic [4:0] hex2nib(input logic [7:0] c);
    logic [7:0] t;
    t = 8'h00;
    if (c >= 8'h30 && c <= 8'h39) begin
      t = c - 8'h30;
      return {1'b1, t[3:0]};
    end else if (c >= 8'h41 && c <= 8'h46) begin
      t = c - 8'h37;
      return {1'b1, t[3:0]};
    end else if (c >= 8'h61 && c <= 8'h66) begin
      t = c - 8'h57;
      return {1'b1, t[3:0]};
    end
    return 5'h00;
  endfunction : hex2nib

  function automatic logic [7:0] nib2hex(input logic [3:0] n);
    return (n < 4'hA) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
  endfunction : nib2hex

  function automatic logic [7:0] alarm_digit(input rach_alarm_e m);
    case (m)
      ALM_MOM: return 8'h31;
      ALM_LATCH: return 8'h32;
      default: return 8'h30;
    endcase
  endfunction : alarm_digit
endpackage : rach_pkg

//--- design/rach_sync.sv
// two-flop synchroniser for pin-level inputs
// assumes inputs are quasi-static levels; no bus coherency across bits
`timescale 1ns/1ns
module rach_sync #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_ce,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else if (i_ce) begin
      meta_reg <= i_async;
      sync_reg <= meta_reg;
    end
  end

  assign o_sync = sync_reg;
endmodule : rach_sync

//--- design/rach_tx.sv
// reply serialiser: sends up to nine bytes, byte 0 in the low bits
// assumes the byte sink takes data when valid and ready are both high
`timescale 1ns/1ns
module rach_tx (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_ce,
  input wire logic i_load,
  input wire logic [71:0] i_bytes,
  input wire logic [3:0] i_count,
  input wire logic i_ready,
  output logic [7:0] o_data,
  output logic o_valid,
  output logic o_busy
);
  logic [71:0] buf_reg, buf_next;
  logic [3:0] left_reg, left_next;
  logic [7:0] data_reg, data_next;
  logic valid_reg, valid_next;

  always_comb begin
    buf_next = buf_reg;
    left_next = left_reg;
    data_next = data_reg;
    valid_next = valid_reg;
    if (i_load) begin
      data_next = i_bytes[7:0];
      buf_next = {8'h00, i_bytes[71:8]};
      left_next = i_count - 4'h1;
      valid_next = 1'b1;
    end else if (valid_reg && i_ready) begin
      if (left_reg != 4'h0) begin
        data_next = buf_reg[7:0];
        buf_next = {8'h00, buf_reg[71:8]};
        left_next = left_reg - 4'h1;
      end else begin
        valid_next = 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      buf_reg <= 72'h0;
      left_reg <= 4'h0;
      data_reg <= 8'h00;
      valid_reg <= 1'b0;
    end else if (i_ce) begin
      buf_reg <= buf_next;
      left_reg <= left_next;
      data_reg <= data_next;
      valid_reg <= valid_next;
    end
  end

  assign o_data = data_reg;
  assign o_valid = valid_reg;
  assign o_busy = valid_reg;
endmodule : rach_tx

//--- design/rach_top.sv
// command interpreter for relay, polarity and high alarm commands
// assumes a same-clock byte receiver and byte transmitter with valid/ready
`timescale 1ns/1ns
module rach_top (
  input wire logic I_REF_CLK,
  input wire logic I_ARST_N,
  input wire logic I_CLK_EN,
  input wire logic [7:0] I_RX_DATA,
  input wire logic I_RX_VALID,
  input wire logic I_RX_ERR,
  output logic O_RX_READY,
  output logic [7:0] O_TX_DATA,
  output logic O_TX_VALID,
  input wire logic I_TX_READY,
  input wire logic [7:0] I_MODULE_ADDR,
  input wire logic I_SENSOR_LINKED,
  input wire logic I_OVER_LIMIT,
  input wire logic I_PIR_TRIGGER,
  input wire logic I_DIGITAL_IN,
  output logic O_RELAY_PIN,
  output logic O_RELAY_ACTIVE,
  output logic O_ALARM,
  output logic [1:0] O_ALARM_SETTING,
  output logic [7:0] O_POLARITY
);
  logic [9:0] pins_s;
  logic [7:0] addr_s;
  logic pir_s, din_s;
  logic tx_busy;

  rach_sync #(.W(10)) u_sync (
    .i_clk(I_REF_CLK),
    .i_arst_n(I_ARST_N),
    .i_ce(I_CLK_EN),
    .i_async({I_MODULE_ADDR, I_PIR_TRIGGER, I_DIGITAL_IN}),
    .o_sync(pins_s)
  );
  assign addr_s = pins_s[9:2];
  assign pir_s = pins_s[1];
  assign din_s = pins_s[0];

  // frame receiver state
  rach_pkg::rach_state_e state_reg, state_next;
  logic [7:0] frame_reg [10];
  logic [7:0] frame_next [10];
  logic [3:0] len_reg, len_next;
  logic err_reg, err_next;
  logic ovf_reg, ovf_next;
  logic rdy_reg, rdy_next;

  // decode results
  logic dec, frame_end, reply_go, ok;
  logic cmd_do, cmd_stat, cmd_chc, cmd_aoff, cmd_aon, cmd_rp, cmd_sp;
  logic [4:0] h1, h2, h3, h4;
  logic [7:0] val;
  localparam int REPLY_MAX_L = rach_pkg::REPLY_MAX;
  logic [7:0] rep [REPLY_MAX_L];
  logic [3:0] rep_len;
  logic [71:0] rep_flat;

  // device state
  logic manual_reg, manual_next;
  logic [7:0] pol_reg, pol_next;
  rach_pkg::rach_alarm_e mode_reg, mode_next;
  logic latch_reg, latch_next;
  logic clr;
  logic act_next, pin_next, alarm_next;
  logic act_reg, pin_reg, alarm_reg;

  assign dec = (state_reg == rach_pkg::ST_DECODE);
  assign frame_end = (state_reg == rach_pkg::ST_RECV) && I_RX_VALID
    && (I_RX_DATA == rach_pkg::CHR_CR);

  always_comb begin
    h1 = rach_pkg::hex2nib(frame_reg[1]);
    h2 = rach_pkg::hex2nib(frame_reg[2]);
    h3 = rach_pkg::hex2nib(frame_reg[len_reg - 4'h2]);
    h4 = rach_pkg::hex2nib(frame_reg[len_reg - 4'h1]);
    val = {h3[3:0], h4[3:0]};
    cmd_do = frame_reg[0] == rach_pkg::CHR_AT && len_reg == rach_pkg::LEN_DO
      && frame_reg[3] == rach_pkg::CHR_D && frame_reg[4] == rach_pkg::CHR_O && h3[4] && h4[4];
    cmd_chc = frame_reg[0] == rach_pkg::CHR_AT && len_reg == rach_pkg::LEN_DO
      && frame_reg[3] == rach_pkg::CHR_C && frame_reg[4] == rach_pkg::CHR_H
      && frame_reg[5] == rach_pkg::CHR_C && frame_reg[6] == rach_pkg::CHR_ZERO;
    cmd_stat = frame_reg[0] == rach_pkg::CHR_AT && len_reg == rach_pkg::LEN_STATUS
      && frame_reg[3] == rach_pkg::CHR_D && frame_reg[4] == rach_pkg::CHR_I;
    cmd_aoff = frame_reg[0] == rach_pkg::CHR_AT && len_reg == rach_pkg::LEN_STATUS
      && frame_reg[3] == rach_pkg::CHR_D && frame_reg[4] == rach_pkg::CHR_A;
    cmd_aon = frame_reg[0] == rach_pkg::CHR_AT && len_reg == rach_pkg::LEN_MID
      && frame_reg[3] == rach_pkg::CHR_E && frame_reg[4] == rach_pkg::CHR_A;
    cmd_rp = frame_reg[0] == rach_pkg::CHR_TILDE && len_reg == rach_pkg::LEN_SHORT
      && frame_reg[3] == rach_pkg::CHR_D;
    cmd_sp = frame_reg[0] == rach_pkg::CHR_TILDE && len_reg == rach_pkg::LEN_MID
      && frame_reg[3] == rach_pkg::CHR_D && h3[4] && h4[4];
    // silence on syntax, link error or foreign address
    reply_go = dec && !err_reg && !ovf_reg && h1[4] && h2[4]
      && {h1[3:0], h2[3:0]} == addr_s
      && (cmd_do || cmd_chc || cmd_stat || cmd_aoff || cmd_aon || cmd_rp || cmd_sp);
    ok = 1'b1;
    if (cmd_do) begin
      ok = !I_SENSOR_LINKED && (val == rach_pkg::RELAY_OFF || val == rach_pkg::RELAY_ON);
    end else if (cmd_sp) begin
      ok = (val & rach_pkg::POL_RSVD_MASK) == 8'h00;
    end else if (cmd_aon) begin
      ok = frame_reg[5] == rach_pkg::CHR_M || frame_reg[5] == rach_pkg::CHR_L;
    end
  end

  // reply assembly, carriage return after the last field
  always_comb begin
    for (int i = 0; i < REPLY_MAX_L; i++) begin
      rep[i] = rach_pkg::CHR_CR;
    end
    rep[0] = ok ? rach_pkg::CHR_OK : rach_pkg::CHR_BAD;
    rep[1] = rach_pkg::nib2hex(addr_s[7:4]);
    rep[2] = rach_pkg::nib2hex(addr_s[3:0]);
    rep_len = 4'h4;
    if (cmd_stat) begin
      rep[3] = rach_pkg::alarm_digit(mode_reg);
      rep[4] = rach_pkg::CHR_ZERO;
      rep[5] = rach_pkg::nib2hex({3'h0, act_reg});
      rep[6] = rach_pkg::CHR_ZERO;
      rep[7] = rach_pkg::nib2hex({2'h0, din_s, pir_s});
      rep_len = 4'h9;
    end else if (cmd_rp) begin
      rep[3] = rach_pkg::nib2hex(pol_reg[7:4]);
      rep[4] = rach_pkg::nib2hex(pol_reg[3:0]);
      rep_len = 4'h6;
    end
  end

  generate
    for (genvar g = 0; g < REPLY_MAX_L; g++) begin : g_flat
      assign rep_flat[g*8 +: 8] = rep[g];
    end
  endgenerate

  // receiver and sequencer
  always_comb begin
    state_next = state_reg;
    frame_next = frame_reg;
    len_next = len_reg;
    err_next = err_reg;
    ovf_next = ovf_reg;
    case (state_reg)
      rach_pkg::ST_RECV: begin
        if (I_RX_VALID) begin
          if (I_RX_ERR) begin
            err_next = 1'b1;
          end
          if (I_RX_DATA == rach_pkg::CHR_CR) begin
            state_next = rach_pkg::ST_DECODE;
          end else if (len_reg < rach_pkg::FRAME_MAX) begin
            frame_next[len_reg] = I_RX_DATA;
            len_next = len_reg + 4'h1;
          end else begin
            ovf_next = 1'b1;
          end
        end
      end
      rach_pkg::ST_DECODE: begin
        len_next = 4'h0;
        err_next = 1'b0;
        ovf_next = 1'b0;
        state_next = reply_go ? rach_pkg::ST_SEND : rach_pkg::ST_RECV;
      end
      rach_pkg::ST_SEND: begin
        if (!tx_busy) begin
          state_next = rach_pkg::ST_RECV;
        end
      end
      default: state_next = rach_pkg::ST_RECV;
    endcase
    rdy_next = (state_next == rach_pkg::ST_RECV);
  end

  // command effects
  always_comb begin
    manual_next = manual_reg;
    pol_next = pol_reg;
    mode_next = mode_reg;
    clr = 1'b0;
    if (reply_go && ok) begin
      if (cmd_do) begin
        manual_next = val[0];
      end
      if (cmd_sp) begin
        pol_next = val;
      end
      if (cmd_aoff) begin
        mode_next = rach_pkg::ALM_OFF;
      end
      if (cmd_aon) begin
        mode_next = (frame_reg[5] == rach_pkg::CHR_M) ? rach_pkg::ALM_MOM
          : rach_pkg::ALM_LATCH;
      end
      clr = cmd_chc;
    end
    // a new over-limit wins over a clear in the same cycle
    latch_next = (latch_reg && !clr)
      || (mode_reg == rach_pkg::ALM_LATCH && I_OVER_LIMIT);
    alarm_next = (mode_next == rach_pkg::ALM_MOM) ? I_OVER_LIMIT
      : (mode_next == rach_pkg::ALM_LATCH) ? latch_next : 1'b0;
    act_next = I_SENSOR_LINKED ? pir_s : manual_next;
    pin_next = act_next ^ pol_next[rach_pkg::POL_BIT];
  end

  always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      state_reg <= rach_pkg::ST_RECV;
      for (int i = 0; i < 10; i++) begin
        frame_reg[i] <= 8'h00;
      end
      len_reg <= 4'h0;
      err_reg <= 1'b0;
      ovf_reg <= 1'b0;
      rdy_reg <= 1'b1;
      manual_reg <= 1'b0;
      pol_reg <= rach_pkg::POL_RESET;
      mode_reg <= rach_pkg::ALM_OFF;
      latch_reg <= 1'b0;
      act_reg <= 1'b0;
      pin_reg <= 1'b0;
      alarm_reg <= 1'b0;
    end else if (I_CLK_EN) begin
      state_reg <= state_next;
      frame_reg <= frame_next;
      len_reg <= len_next;
      err_reg <= err_next;
      ovf_reg <= ovf_next;
      rdy_reg <= rdy_next;
      manual_reg <= manual_next;
      pol_reg <= pol_next;
      mode_reg <= mode_next;
      latch_reg <= latch_next;
      act_reg <= act_next;
      pin_reg <= pin_next;
      alarm_reg <= alarm_next;
    end
  end

  rach_tx u_tx (
    .i_clk(I_REF_CLK),
    .i_arst_n(I_ARST_N),
    .i_ce(I_CLK_EN),
    .i_load(reply_go),
    .i_bytes(rep_flat),
    .i_count(rep_len),
    .i_ready(I_TX_READY),
    .o_data(O_TX_DATA),
    .o_valid(O_TX_VALID),
    .o_busy(tx_busy)
  );

  assign O_RX_READY = rdy_reg;
  assign O_RELAY_PIN = pin_reg;
  assign O_RELAY_ACTIVE = act_reg;
  assign O_ALARM = alarm_reg;
  assign O_ALARM_SETTING = mode_reg;
  assign O_POLARITY = pol_reg;

  // checks; they are disabled during reset and while the clock enable is low
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_ARST_N || !I_CLK_EN);

  sequence s_frame_end;
    frame_end;
  endsequence
  sequence s_accept;
    reply_go && ok;
  endsequence

  a_frame_cr: assert property (s_frame_end |=> dec)
    else $error("carriage return did not end the frame");
  a_silent_drop: assert property (dec && !reply_go |=> !O_TX_VALID && O_RX_READY)
    else $error("reply sent for a dropped frame");
  a_reply_head: assert property (reply_go |=> O_TX_VALID
      && O_TX_DATA == (($past(ok)) ? rach_pkg::CHR_OK : rach_pkg::CHR_BAD))
    else $error("reply head wrong");
  a_relay_locked: assert property (dec && cmd_do && I_SENSOR_LINKED |=> $stable(manual_reg))
    else $error("manual relay changed while linked");
  a_relay_set: assert property (s_accept ##0 cmd_do && !I_SENSOR_LINKED
      |=> manual_reg == $past(val[0]) ##1 O_RELAY_ACTIVE == manual_reg || I_SENSOR_LINKED)
    else $error("relay not set as commanded");
  a_pol_keep: assert property (reply_go && cmd_sp && !ok |=> $stable(pol_reg))
    else $error("reserved polarity value stored");
  a_pol_store: assert property (s_accept ##0 cmd_sp |=> O_POLARITY == $past(val))
    else $error("polarity byte not stored");
  a_pin_sense: assert property (O_RELAY_PIN == (O_RELAY_ACTIVE ^ O_POLARITY[rach_pkg::POL_BIT]))
    else $error("relay pin sense wrong");
  a_latch_hold: assert property (latch_reg && !clr |=> latch_reg)
    else $error("latched alarm dropped without clear");
  a_alarm_cfg: assert property (s_accept ##0 cmd_aoff |=> mode_reg == rach_pkg::ALM_OFF ##1 !O_ALARM
      || mode_reg != rach_pkg::ALM_OFF)
    else $error("alarm not disabled");
  a_latch_set: assert property (mode_reg == rach_pkg::ALM_LATCH && I_OVER_LIMIT |=> latch_reg)
    else $error("latched alarm not set by over-limit");
  a_alarm_mom: assert property (mode_reg == rach_pkg::ALM_MOM && mode_next == rach_pkg::ALM_MOM
      |=> O_ALARM == $past(I_OVER_LIMIT))
    else $error("momentary alarm does not follow limit");
  // a reply byte must not move or vanish while the sink stalls
  a_tx_hold: assert property (O_TX_VALID && !I_TX_READY |=> O_TX_VALID && $stable(O_TX_DATA))
    else $error("reply byte changed while stalled");
  a_rx_closed: assert property (O_TX_VALID |-> !O_RX_READY)
    else $error("receiver open during reply");
endmodule : rach_top

//--- sim/rach_host.sv
// remote host model: sends ascii frames byte by byte and collects replies
// assumes the handler shares its clock; the testbench calls send directly
`timescale 1ns/1ns
module rach_host (
  input wire logic i_clk,
  input wire logic i_rx_ready,
  input wire logic [7:0] i_tx_data,
  input wire logic i_tx_valid,
  output logic [7:0] o_rx_data,
  output logic o_rx_valid,
  output logic o_rx_err,
  output logic o_tx_ready
);
  logic [7:0] q [$];
  logic slow;
  logic hung;

  initial begin
    o_rx_data = 8'h00;
    o_rx_valid = 1'b0;
    o_rx_err = 1'b0;
    o_tx_ready = 1'b1;
    slow = 1'b0;
    hung = 1'b0;
  end

  // frame is the characters then a carriage return, held until taken
  task automatic send(input string s, input logic err);
    logic [7:0] b;
    int n;
    b = 8'h00;
    for (int i = 0; i <= s.len(); i++) begin
      b = (i == s.len()) ? 8'h0D : 8'(s[i]);
      @(posedge i_clk);
      o_rx_data <= b;
      o_rx_valid <= 1'b1;
      o_rx_err <= err;
      n = 0;
      @(negedge i_clk);
      while (i_rx_ready !== 1'b1 && n < 100) begin
        @(negedge i_clk);
        n++;
      end
      if (n == 100) hung = 1'b1;
    end
    @(posedge i_clk);
    o_rx_valid <= 1'b0;
    o_rx_err <= 1'b0;
    // released data line must not keep looking like a valid byte
    o_rx_data <= ~b;
  endtask : send

  // slow mode stalls every other cycle
  always @(posedge i_clk) o_tx_ready <= (slow === 1'b1) ? ~o_tx_ready : 1'b1;

  always @(negedge i_clk) begin
    if (i_tx_valid === 1'b1 && o_tx_ready === 1'b1) q.push_back(i_tx_data);
  end
endmodule : rach_host

//--- sim/rach_top_tb.sv
// self-checking bench for the relay and alarm command handler
// assumes rach_host as the far side; module address 3A unless changed
`timescale 1ns/1ns
module rach_top_tb;
  logic clk;
  logic arst_n;
  logic [7:0] addr;
  logic linked;
  logic over;
  logic pir;
  logic din;
  logic ce;
  logic [7:0] rx_data;
  logic rx_valid;
  logic rx_err;
  logic rx_ready;
  logic [7:0] tx_data;
  logic tx_valid;
  logic tx_ready;
  logic relay_pin;
  logic relay_act;
  logic alarm;
  logic [1:0] alm_set;
  logic [7:0] polarity;
  int n_errors;
  int checks;

  rach_host u_host (.i_clk(clk), .i_rx_ready(rx_ready), .i_tx_data(tx_data),
    .i_tx_valid(tx_valid), .o_rx_data(rx_data), .o_rx_valid(rx_valid),
    .o_rx_err(rx_err), .o_tx_ready(tx_ready));

  rach_top u_dut (.I_REF_CLK(clk), .I_ARST_N(arst_n), .I_CLK_EN(ce),
    .I_RX_DATA(rx_data), .I_RX_VALID(rx_valid), .I_RX_ERR(rx_err),
    .O_RX_READY(rx_ready), .O_TX_DATA(tx_data), .O_TX_VALID(tx_valid),
    .I_TX_READY(tx_ready), .I_MODULE_ADDR(addr), .I_SENSOR_LINKED(linked),
    .I_OVER_LIMIT(over), .I_PIR_TRIGGER(pir), .I_DIGITAL_IN(din),
    .O_RELAY_PIN(relay_pin), .O_RELAY_ACTIVE(relay_act), .O_ALARM(alarm),
    .O_ALARM_SETTING(alm_set), .O_POLARITY(polarity));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string what, input logic [71:0] seen, input logic [71:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  function automatic logic [71:0] pack(input string s);
    logic [71:0] v;
    v = 72'h0;
    for (int i = 0; i < s.len(); i++) v = {v[63:0], 8'(s[i])};
    return v;
  endfunction : pack

  // expected reply without its carriage return; empty means silence
  task automatic cmd(input string s, input logic err, input string exp);
    string e;
    logic [71:0] v;
    int n;
    e = (exp.len() > 0) ? {exp, "\r"} : "";
    v = 72'h0;
    n = 0;
    u_host.q.delete();
    u_host.send(s, err);
    while (n < 60 && !(e.len() > 0 && u_host.q.size() == e.len())) begin
      @(negedge clk);
      n++;
    end
    if (u_host.hung === 1'b1 || (e.len() > 0 && n == 60)) begin
      n_errors++;
      $display("CHECK FAILED handshake of %s expected done seen timeout", s);
      report_and_stop();
    end
    foreach (u_host.q[i]) v = {v[63:0], u_host.q[i]};
    chk(s, v, pack(e));
  endtask : cmd

  task automatic over_pulse(input logic keep);
    @(posedge clk);
    over <= 1'b1;
    repeat (3) @(negedge clk);
    chk("alarm raised", 72'(alarm), 72'(keep));
    @(posedge clk);
    over <= 1'b0;
    repeat (3) @(negedge clk);
  endtask : over_pulse

  initial begin
    arst_n = 1'b0;
    addr = 8'h3A;
    linked = 1'b1;
    over = 1'b0;
    pir = 1'b0;
    din = 1'b1;
    ce = 1'b1;
    n_errors = 0;
    checks = 0;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(negedge clk);
    chk("polarity reset", 72'(polarity), 72'h0);
    chk("setting reset", 72'(alm_set), 72'h0);
    $display("test reset done");

    cmd("@3ADO01", 1'b0, "?3A");
    chk("relay kept", 72'(relay_act), 72'h0);
    @(posedge clk);
    linked <= 1'b0;
    repeat (2) @(negedge clk);
    chk("relay still off", 72'(relay_act), 72'h0);
    cmd("@3ADO01", 1'b0, "!3A");
    chk("relay on", 72'(relay_act), 72'h1);
    chk("pin on", 72'(relay_pin), 72'h1);
    cmd("@3ADO02", 1'b0, "?3A");
    cmd("@3ADI", 1'b0, "!3A00102");
    $display("test relay done");

    cmd("~3AD07", 1'b0, "?3A");
    chk("polarity kept", 72'(polarity), 72'h0);
    cmd("~3AD04", 1'b0, "!3A");
    chk("polarity set", 72'(polarity), 72'h4);
    chk("pin inverted", 72'(relay_pin), 72'h0);
    cmd("~3AD", 1'b0, "!3A04");
    cmd("@3ADO00", 1'b0, "!3A");
    chk("pin idle high", 72'(relay_pin), 72'h1);
    @(posedge clk);
    pir <= 1'b1;
    din <= 1'b0;
    cmd("@3ADI", 1'b0, "!3A00001");
    $display("test polarity done");

    cmd("@3AEAL", 1'b0, "!3A");
    chk("latching", 72'(alm_set), 72'h2);
    cmd("@3ADI", 1'b0, "!3A20001");
    over_pulse(1'b1);
    chk("latch held", 72'(alarm), 72'h1);
    cmd("@3ACHC0", 1'b0, "!3A");
    chk("latch cleared", 72'(alarm), 72'h0);
    cmd("@3AEAM", 1'b0, "!3A");
    cmd("@3ADI", 1'b0, "!3A10001");
    @(posedge clk);
    ce <= 1'b0;
    over <= 1'b1;
    repeat (3) @(negedge clk);
    chk("alarm frozen", 72'(alarm), 72'h0);
    @(posedge clk);
    ce <= 1'b1;
    repeat (2) @(negedge clk);
    chk("alarm thawed", 72'(alarm), 72'h1);
    @(posedge clk);
    over <= 1'b0;
    over_pulse(1'b1);
    chk("momentary off", 72'(alarm), 72'h0);
    cmd("@3AEAX", 1'b0, "?3A");
    cmd("@3ADA", 1'b0, "!3A");
    chk("disabled", 72'(alm_set), 72'h0);
    over_pulse(1'b0);
    $display("test alarm done");

    cmd("@3BDI", 1'b0, "");
    cmd("@3ADI", 1'b1, "");
    cmd("@3AZZ", 1'b0, "");
    cmd("@3ADO01", 1'b1, "");
    chk("no effect", 72'(relay_act), 72'h0);
    $display("test silence done");

    @(posedge clk);
    addr <= 8'hFF;
    u_host.slow = 1'b1;
    repeat (4) @(negedge clk);
    cmd("~FFD", 1'b0, "!FF04");
    @(posedge clk);
    addr <= 8'h00;
    repeat (4) @(negedge clk);
    cmd("@00DO01", 1'b0, "!00");
    $display("test address done");
    report_and_stop();
  end
endmodule : rach_top_tb
